// file: verilog/ecup_locators.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ecup_locators
   import ecup_pkg::*;
#(
   parameter int SEG_FIRST = ECUP_SEG_FIRST,
   parameter int SEG_COUNT = ECUP_SEG_COUNT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic page_start,
   input wire logic byte_valid,
   input wire ecup_byte_t byte_in,
   input wire logic check_valid,
   input wire ecup_check_t check_in,
   output logic [SEG_COUNT-1:0] seg_error,
   output logic busy
);

   // ==========================================================
   // elaboration checks
   initial begin
      if (SEG_FIRST + SEG_COUNT != 16 || SEG_COUNT < 1) begin
         $error("ecup_locators: segments must end at segment 15");
      end
      if (SEG_COUNT > 8) begin
         $error("ecup_locators: the read select holds at most eight segments");
      end
      if (ECUP_PAR_W != ECUP_SEG_AW + 3) begin
         $error("ecup_locators: parity must span byte index and bit offset");
      end
      if (ECUP_PAGE_AW - ECUP_SEG_AW != 4) begin
         $error("ecup_locators: segment number must fit four address bits");
      end
      if (ECUP_SEG15_ADDR - ECUP_SEG10_ADDR != 32'(4 * (SEG_COUNT - 1))) begin
         $error("ecup_locators: locator addresses must match the segment count");
      end
      if (ECUP_STAT_CHK_LSB - ECUP_STAT_ERR_LSB < SEG_COUNT) begin
         $error("ecup_locators: status fields would overlap");
      end
   end

   // ==========================================================
   // address decode for the locator read mux
   function automatic logic [3:0] loc_index(input logic [31:0] a);
      logic [31:0] off;
      off = a - ECUP_SEG10_ADDR;
      if (a >= ECUP_SEG10_ADDR && a <= ECUP_SEG15_ADDR && off[1:0] == 2'h0) begin
         return {1'b1, off[4:2]};
      end
      return 4'h0;
   endfunction

   // ==========================================================
   // control and status
   ecup_ctrl_t ctrl_ff;
   ecup_ctrl_t nxt_ctrl;
   logic clr_ff;
   logic nxt_clr;
   logic [SEG_COUNT-1:0] err_ff;
   logic [SEG_COUNT-1:0] nxt_err;
   logic [SEG_COUNT-1:0] chk_ff;
   logic [SEG_COUNT-1:0] nxt_chk;
   logic [2:0] boff_ff [SEG_COUNT];
   logic [2:0] nxt_boff [SEG_COUNT];
   logic [7:0] bidx_ff [SEG_COUNT];
   logic [7:0] nxt_bidx [SEG_COUNT];
   logic [ECUP_PAR_W-1:0] par [SEG_COUNT];
   logic [2:0] syn_boff [SEG_COUNT];
   logic [7:0] syn_bidx [SEG_COUNT];
   logic [SEG_COUNT-1:0] syn_err;
   logic [SEG_COUNT-1:0] seg_hit_byte;
   logic [SEG_COUNT-1:0] seg_hit_check;

   // ==========================================================
   // bus slave state
   logic wr_pend_ff;
   logic nxt_wr_pend;
   logic [31:0] wr_addr_ff;
   logic [31:0] nxt_wr_addr;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic ready_ff;
   logic nxt_ready;
   logic seg_err_out_ff;
   logic nxt_resp;
   logic [SEG_COUNT-1:0] seg_error_ff;
   logic [SEG_COUNT-1:0] nxt_seg_error;
   logic busy_ff;
   logic nxt_busy;
   logic acc_clr;
   logic addr_phase;
   logic ctrl_write;
   logic [3:0] rd_sel;
   logic [3:0] byte_seg;

   // ==========================================================
   // segment routing: byte address bits 11:8 pick the segment
   // bytes of lower segments miss every hit line and are dropped
   always_comb begin
      byte_seg = byte_in.addr[ECUP_PAGE_AW-1:ECUP_SEG_AW];
      acc_clr = page_start | clr_ff;
      for (int i = 0; i < SEG_COUNT; i++) begin
         seg_hit_byte[i] = ctrl_ff.enable && byte_valid && (byte_seg == 4'(SEG_FIRST + i));
         seg_hit_check[i] = ctrl_ff.enable && ctrl_ff.read_mode && check_valid
            && (check_in.seg == 4'(SEG_FIRST + i));
      end
   end

   genvar g;
   generate
      for (g = 0; g < SEG_COUNT; g++) begin : g_seg
         ecup_seg_acc #(
            .PAR_W(ECUP_PAR_W)
         ) u_acc (
            .hclk(hclk),
            .hresetn(hresetn),
            .ce(ce),
            .clr(acc_clr),
            .byte_valid(seg_hit_byte[g]),
            .byte_index(byte_in.addr[ECUP_SEG_AW-1:0]),
            .byte_data(byte_in.data),
            .parity(par[g])
         );
         ecup_syndrome u_syn (
            .computed(par[g]),
            .stored(check_in.parity),
            .bit_offset(syn_boff[g]),
            .byte_index(syn_bidx[g]),
            .error(syn_err[g])
         );
      end
   endgenerate

   // ==========================================================
   // locator capture on read compare
   always_comb begin
      nxt_err = err_ff;
      nxt_chk = chk_ff;
      for (int i = 0; i < SEG_COUNT; i++) begin
         nxt_boff[i] = boff_ff[i];
         nxt_bidx[i] = bidx_ff[i];
         if (acc_clr) begin
            nxt_boff[i] = 3'h0;
            nxt_bidx[i] = 8'h0;
            nxt_chk[i] = 1'b0;
            nxt_err[i] = 1'b0;
         end
         // the compare happens after the page; a compare in the clear cycle still lands
         if (seg_hit_check[i]) begin
            nxt_boff[i] = syn_boff[i];
            nxt_bidx[i] = syn_bidx[i];
            nxt_chk[i] = 1'b1;
            nxt_err[i] = syn_err[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_ff <= '0;
         chk_ff <= '0;
         for (int i = 0; i < SEG_COUNT; i++) begin
            boff_ff[i] <= 3'h0;
            bidx_ff[i] <= 8'h0;
         end
      end else if (ce) begin
         err_ff <= nxt_err;
         chk_ff <= nxt_chk;
         for (int i = 0; i < SEG_COUNT; i++) begin
            boff_ff[i] <= nxt_boff[i];
            bidx_ff[i] <= nxt_bidx[i];
         end
      end
   end

   // ==========================================================
   // register image of one segment
   function automatic logic [31:0] loc_word(input logic [ECUP_PAR_W-1:0] p, input logic [7:0] bi,
                                            input logic [2:0] bo);
      ecup_loc_t w;
      w = ECUP_LOC_RESET;
      w.parity = p;
      w.byte_index = bi;
      w.bit_offset = bo;
      return w;
   endfunction

   // ==========================================================
   // ahb-lite slave, zero wait states; read data is built in the
   // address phase so hrdata can leave a flop in the data phase
   always_comb begin
      addr_phase = hsel && hready && htrans[1];
      rd_sel = loc_index(haddr);
      nxt_wr_pend = addr_phase && hwrite;
      nxt_wr_addr = addr_phase ? haddr : wr_addr_ff;
      // zero wait states and only okay: holes read as zero instead of failing
      nxt_ready = 1'b1;
      nxt_resp = 1'b0;
      nxt_rdata = 32'h0;
      if (addr_phase && !hwrite) begin
         if (rd_sel[3] && int'(rd_sel[2:0]) < SEG_COUNT) begin
            nxt_rdata = loc_word(par[rd_sel[2:0]], bidx_ff[rd_sel[2:0]], boff_ff[rd_sel[2:0]]);
         end else if (haddr == ECUP_CTRL_ADDR) begin
            nxt_rdata[ECUP_CTRL_EN_BIT] = ctrl_ff.enable;
            nxt_rdata[ECUP_CTRL_RD_BIT] = ctrl_ff.read_mode;
         end else if (haddr == ECUP_STATUS_ADDR) begin
            nxt_rdata[ECUP_STAT_CHK_LSB +: SEG_COUNT] = chk_ff;
            nxt_rdata[ECUP_STAT_ERR_LSB +: SEG_COUNT] = err_ff;
         end
      end
   end

   // locator registers are read-only; writes to them are dropped
   always_comb begin
      ctrl_write = wr_pend_ff && (wr_addr_ff == ECUP_CTRL_ADDR);
      nxt_ctrl = ctrl_ff;
      nxt_clr = 1'b0;
      if (ctrl_write) begin
         nxt_ctrl.enable = hwdata[ECUP_CTRL_EN_BIT];
         nxt_ctrl.read_mode = hwdata[ECUP_CTRL_RD_BIT];
         nxt_clr = hwdata[ECUP_CTRL_CLR_BIT];
      end
   end

   // ==========================================================
   // control flops; a clear is a one-cycle pulse an edge after its write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= ECUP_CTRL_RESET;
         clr_ff <= 1'b0;
      end else if (ce) begin
         ctrl_ff <= nxt_ctrl;
         clr_ff <= nxt_clr;
      end
   end

   // ==========================================================
   // bus flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 32'h0;
         rdata_ff <= 32'h0;
         ready_ff <= 1'b1;
         seg_err_out_ff <= 1'b0;
      end else if (ce) begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         rdata_ff <= nxt_rdata;
         ready_ff <= nxt_ready;
         seg_err_out_ff <= nxt_resp;
      end
   end

   // ==========================================================
   // output flags; the error flags trail the status bits by one
   // edge so every output leaves a flop of its own
   always_comb begin
      nxt_seg_error = err_ff;
      // busy only while a read check is still owed for some segment
      nxt_busy = ctrl_ff.enable && ctrl_ff.read_mode && (chk_ff != {SEG_COUNT{1'b1}});
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seg_error_ff <= '0;
         busy_ff <= 1'b0;
      end else if (ce) begin
         seg_error_ff <= nxt_seg_error;
         busy_ff <= nxt_busy;
      end
   end

   assign hrdata = rdata_ff;
   assign hreadyout = ready_ff;
   assign hresp = seg_err_out_ff;
   assign seg_error = seg_error_ff;
   assign busy = busy_ff;

endmodule
`default_nettype wire

// file: verilog/ecup_pkg.sv
package ecup_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [31:0] ECUP_SEG10_ADDR = 32'hffffe838;
   localparam logic [31:0] ECUP_SEG11_ADDR = 32'hffffe83c;
   localparam logic [31:0] ECUP_SEG12_ADDR = 32'hffffe840;
   localparam logic [31:0] ECUP_SEG13_ADDR = 32'hffffe844;
   localparam logic [31:0] ECUP_SEG14_ADDR = 32'hffffe848;
   localparam logic [31:0] ECUP_SEG15_ADDR = 32'hffffe84c;
   localparam logic [31:0] ECUP_CTRL_ADDR = 32'hffffe860;
   localparam logic [31:0] ECUP_STATUS_ADDR = 32'hffffe864;

   // ==========================================================
   // page geometry
   localparam int ECUP_SEG_FIRST = 10;
   localparam int ECUP_SEG_COUNT = 6;
   localparam int ECUP_PAGE_AW = 12;
   localparam int ECUP_SEG_AW = 8;
   localparam int ECUP_PAR_W = 11;

   // ==========================================================
   // locator, control and status register fields
   localparam int ECUP_BIT_LSB = 0;
   localparam int ECUP_WORD_LSB = 3;
   localparam int ECUP_PAR_LSB = 12;
   localparam int ECUP_CTRL_EN_BIT = 0;
   localparam int ECUP_CTRL_RD_BIT = 1;
   localparam int ECUP_CTRL_CLR_BIT = 2;
   localparam int ECUP_STAT_ERR_LSB = 0;
   localparam int ECUP_STAT_CHK_LSB = 8;
   localparam logic [1:0] ECUP_CTRL_RESET = 2'h0;
   localparam logic [31:0] ECUP_LOC_RESET = 32'h0;

   // ==========================================================
   // bus codes
   localparam logic [1:0] ECUP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] ECUP_HTRANS_SEQ = 2'h3;
   localparam logic [2:0] ECUP_HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic [7:0] rsvd;
      logic zero_hi;
      logic [10:0] parity;
      logic zero_lo;
      logic [7:0] byte_index;
      logic [2:0] bit_offset;
   } ecup_loc_t;

   typedef struct packed {
      logic read_mode;
      logic enable;
   } ecup_ctrl_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] data;
   } ecup_byte_t;

   typedef struct packed {
      logic [3:0] seg;
      logic [10:0] parity;
   } ecup_check_t;

endpackage

// file: verilog/ecup_seg_acc.sv
`timescale 1ns/1ns
`default_nettype none
module ecup_seg_acc
   import ecup_pkg::*;
#(
   parameter int PAR_W = ECUP_PAR_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic clr,
   input wire logic byte_valid,
   input wire logic [PAR_W-4:0] byte_index,
   input wire logic [7:0] byte_data,
   output logic [PAR_W-1:0] parity
);

   // ==========================================================
   // checks
   initial begin
      if (PAR_W != 11) begin
         $error("ecup_seg_acc: parity width must be 11");
      end
   end

   // ==========================================================
   // fold one byte: xor of the bit numbers of every set bit
   function automatic logic [PAR_W-1:0] fold(input logic [PAR_W-4:0] idx, input logic [7:0] d);
      logic [PAR_W-1:0] acc;
      acc = '0;
      for (int j = 0; j < 8; j++) begin
         if (d[j]) begin
            acc = acc ^ {idx, 3'(j)};
         end
      end
      return acc;
   endfunction

   logic [PAR_W-1:0] par_ff;
   logic [PAR_W-1:0] nxt_par;

   always_comb begin
      nxt_par = par_ff;
      if (clr) begin
         nxt_par = '0;
      end else if (byte_valid) begin
         nxt_par = par_ff ^ fold(byte_index, byte_data);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         par_ff <= '0;
      end else if (ce) begin
         par_ff <= nxt_par;
      end
   end

   assign parity = par_ff;

endmodule
`default_nettype wire

// file: verilog/ecup_syndrome.sv
`timescale 1ns/1ns
`default_nettype none
module ecup_syndrome
   import ecup_pkg::*;
(
   input wire logic [ECUP_PAR_W-1:0] computed,
   input wire logic [ECUP_PAR_W-1:0] stored,
   output logic [2:0] bit_offset,
   output logic [7:0] byte_index,
   output logic error
);

   // ==========================================================
   // a single flipped bit leaves its own bit number as syndrome;
   // two or more errors alias to some other number, so the fields
   // then mean nothing
   logic [ECUP_PAR_W-1:0] syn;

   always_comb begin
      syn = computed ^ stored;
      bit_offset = syn[2:0];
      byte_index = syn[ECUP_PAR_W-1:3];
      error = |syn;
   end

endmodule
`default_nettype wire

// file: tb/ecup_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ecup_checker
   import ecup_pkg::*;
#(
   parameter int SEG_FIRST = ECUP_SEG_FIRST,
   parameter int SEG_COUNT = ECUP_SEG_COUNT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic page_start,
   input wire logic check_valid,
   input wire ecup_check_t check_in,
   input wire logic [SEG_COUNT-1:0] seg_error
);
   // ==========================================================
   // timing
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite && ce;
   endsequence
   sequence s_loc;
      haddr >= ECUP_SEG10_ADDR && haddr <= ECUP_SEG15_ADDR;
   endsequence
   // a flag may only rise two edges after a compare of its own segment
   property p_seg(int i);
      $rose(seg_error[i]) |-> $past(check_valid, 2) && $past(check_in.seg, 2) == i + SEG_FIRST;
   endproperty
   // ==========================================================
   // checks
   a_err_cause: assert property ($rose(|seg_error) |-> $past(check_valid, 2))
      else $error("error flag without a compare");
   a_seg10_span: assert property (p_seg(0))
      else $error("segment 10 flag from wrong segment");
   a_seg11_span: assert property (p_seg(1))
      else $error("segment 11 flag from wrong segment");
   a_seg12_span: assert property (p_seg(2))
      else $error("segment 12 flag from wrong segment");
   a_seg13_span: assert property (p_seg(3))
      else $error("segment 13 flag from wrong segment");
   a_seg14_span: assert property (p_seg(4))
      else $error("segment 14 flag from wrong segment");
   a_seg15_span: assert property (p_seg(5))
      else $error("segment 15 flag from wrong segment");
   a_page_clear: assert property (page_start && !check_valid |-> ##2 !(|seg_error))
      else $error("page start left error flags");
   a_rd_idle: assert property (ce && !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
      else $error("read data outside a read");
   a_res_zero: assert property (s_rd ##0 s_loc |=> hrdata[31:23] == 9'h0 && !hrdata[11])
      else $error("reserved locator bits set");
endmodule
bind ecup_locators ecup_checker #(.SEG_FIRST(SEG_FIRST), .SEG_COUNT(SEG_COUNT)) ecup_checker_i (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .page_start(page_start),
   .check_valid(check_valid), .check_in(check_in), .seg_error(seg_error));
`default_nettype wire

// file: tb/test_nand_page_ecc_error_locators_upper.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_nand_page_ecc_error_locators_upper
   import ecup_pkg::*;
;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rp = 1'b0, ce = 1'b1;
   logic page_start = 0, byte_valid = 0, check_valid = 0;
   logic hready, hreadyout, hresp, busy;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ev;
   logic [1:0] htrans = 2'h0;
   logic [5:0] seg_error, eerr;
   ecup_byte_t byte_in = 20'h0;
   ecup_check_t check_in = 15'h0;
   logic [10:0] acc [10:15];
   logic [10:0] fe [10:15];
   logic [10:0] e;
   logic [31:0] exq [$];
   int err_count = 0, n_compared = 0, seed = 27226;
   assign hready = hreadyout;
   always #2 hclk = ~hclk;
   ecup_locators ecup_locators_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(ECUP_HSIZE_WORD), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .page_start(page_start),
      .byte_valid(byte_valid), .byte_in(byte_in), .check_valid(check_valid), .check_in(check_in),
      .seg_error(seg_error), .busy(busy));
   // ==========================================================
   // read data monitor
   always @(posedge hclk) begin
      if (rp) begin
         ev = exq.pop_front();
         `CHK(hrdata, ev)
         `CHK({hreadyout, hresp}, 2'h2)
      end
      rp <= hsel && hready && htrans[1] && !hwrite;
   end
   // ==========================================================
   // drivers
   task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= ECUP_HTRANS_NONSEQ;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      if (!w) exq.push_back(d);
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask
   // strobe stays up between calls, the caller drops it
   task put(input logic [11:0] a, input logic [7:0] d);
      byte_valid <= 1'b1;
      byte_in <= {a, d};
      for (int b = 0; b < 8; b++) if (d[b] && a[11:8] >= 4'ha) acc[a[11:8]] ^= {a[7:0], 3'(b)};
      @(posedge hclk);
   endtask
   task pulse_page;
      page_start <= 1'b1;
      @(posedge hclk);
      page_start <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      test_done;
   end
   // ==========================================================
   // scenarios
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 8; i++) bus(ECUP_SEG10_ADDR + 4 * i, 1'b0, 32'h0);
      bus(ECUP_SEG12_ADDR, 1'b1, 32'hffffffff);
      bus(ECUP_SEG12_ADDR, 1'b0, 32'h0);
      bus(ECUP_CTRL_ADDR, 1'b1, 32'h1);
      pulse_page;
      for (int s = 10; s < 16; s++) acc[s] = 11'h0;
      // addresses reach into segment 9, which must not count
      for (int i = 0; i < 40; i++) put(12'({$random(seed)} % 1792 + 2304), 8'($random(seed)));
      byte_valid <= 1'b0;
      @(posedge hclk);
      for (int s = 10; s < 16; s++) bus(ECUP_SEG10_ADDR + 4 * (s - 10), 1'b0, {9'h0, acc[s], 12'h0});
      bus(ECUP_CTRL_ADDR, 1'b1, 32'h3);
      // single flips in 10..13, clean 14, double flip (e and ~e) in 15
      eerr = 6'h2f;
      for (int s = 10; s < 16; s++) begin
         e = 11'($random(seed));
         if (e == 11'h0) e = 11'h1;
         fe[s] = (s == 14) ? 11'h0 : (s == 15) ? 11'h7ff : e;
         check_valid <= 1'b1;
         check_in <= {4'(s), acc[s] ^ fe[s]};
         @(posedge hclk);
      end
      check_valid <= 1'b0;
      repeat (2) @(posedge hclk);
      `CHK(seg_error, eerr)
      `CHK(busy, 1'b0)
      for (int s = 10; s < 16; s++) bus(ECUP_SEG10_ADDR + 4 * (s - 10), 1'b0, {9'h0, acc[s], 1'b0, fe[s]});
      bus(ECUP_STATUS_ADDR, 1'b0, {18'h0, 6'h3f, 2'h0, eerr});
      pulse_page;
      `CHK(seg_error, 6'h0)
      bus(ECUP_SEG15_ADDR, 1'b0, 32'h0);
      // a lone single flip in segment 14 after the page clear
      e = 11'($random(seed)) | 11'h1;
      check_valid <= 1'b1;
      check_in <= {4'he, e};
      @(posedge hclk);
      check_valid <= 1'b0;
      repeat (3) @(posedge hclk);
      // a compare under a frozen clock enable must not land
      ce <= 1'b0;
      check_valid <= 1'b1;
      check_in <= {4'ha, e};
      @(posedge hclk);
      ce <= 1'b1;
      check_valid <= 1'b0;
      `CHK(seg_error, 6'h10)
      `CHK(busy, 1'b1)
      bus(ECUP_SEG14_ADDR, 1'b0, {21'h0, e});
      bus(ECUP_STATUS_ADDR, 1'b0, {18'h0, 6'h10, 2'h0, 6'h10});
      // the clear command wipes flags and locators an edge after the write
      bus(ECUP_CTRL_ADDR, 1'b1, 32'h7);
      repeat (3) @(posedge hclk);
      `CHK(seg_error, 6'h0)
      bus(ECUP_STATUS_ADDR, 1'b0, 32'h0);
      bus(ECUP_SEG14_ADDR, 1'b0, 32'h0);
      bus(ECUP_CTRL_ADDR, 1'b0, 32'h3);
      // second reset in mid-run, then a byte with the block disabled
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(ECUP_CTRL_ADDR, 1'b0, 32'h0);
      put(12'ha05, 8'h01);
      byte_valid <= 1'b0;
      @(posedge hclk);
      bus(ECUP_SEG10_ADDR, 1'b0, 32'h0);
      repeat (2) @(posedge hclk);
      test_done;
   end
endmodule
`default_nettype wire
